// ### inc/usb_port_line_control_params.svh
// register map, field positions, line codes and timing constants of the port line control
`ifndef USB_PORT_LINE_CONTROL_PARAMS_SVH
`define USB_PORT_LINE_CONTROL_PARAMS_SVH

// ==========================================================================
// register addresses
`define PORT1_CTRL_ADDR 16'hC08A
`define PORT2_CTRL_ADDR 16'hC0AA

// ==========================================================================
// control register fields
`define BIT_DP_STATUS   13
`define BIT_DM_STATUS   12
`define BIT_LOW_SPEED   10
`define BIT_HOST_ROLE   9
`define BIT_RES_ENABLE  7
`define FORCE_MSB       4
`define FORCE_LSB       3
`define BIT_SUSPEND     2
`define BIT_FRAME_EN    0
`define CTRL_WRITE_MASK 16'h069D
`define CTRL_RESET      16'h0000
`define READ_ZERO       16'h0000

// ==========================================================================
// line force codes
`define FORCE_NORMAL    2'h0
`define FORCE_SE0       2'h1
`define FORCE_J         2'h2
`define FORCE_K         2'h3

// ==========================================================================
// line pairs {d+, d-}
`define LINE_J_FULL     2'h2
`define LINE_J_LOW      2'h1

// ==========================================================================
// timing
`define FRAME_PERIOD_NS 1000000
`define CLOCK_PERIOD_NS 100
`define FRAME_CNT_W     14

`endif

// ### inc/usb_line_pkg.sv
// state types of the port line control and its line synchroniser
`include "usb_port_line_control_params.svh"

package usb_line_pkg;

    // ======================================================================
    // synchroniser state
    typedef struct packed {
        logic [1:0] stage1;
        logic [1:0] stage2;
        logic [1:0] stage3;
        logic [1:0] stable;
    } line_sync_s;

    // ======================================================================
    // control block state
    typedef struct packed {
        logic [1:0][15:0]              ctrl;
        logic [1:0][`FRAME_CNT_W-1:0] frameCnt;
        logic [1:0]                    pullUpDp;
        logic [1:0]                    pullUpDm;
        logic [1:0]                    pullDownDp;
        logic [1:0]                    pullDownDm;
        logic [1:0]                    driveDp;
        logic [1:0]                    driveDm;
        logic [1:0]                    driveOe;
        logic [1:0]                    sofPulse;
        logic [1:0]                    keepalivePulse;
        logic [1:0]                    wakeupSeen;
        logic [1:0]                    portActive;
        logic                          powerDown;
        logic [15:0]                   cpuRdata;
        logic [15:0]                   hppRdata;
    } line_ctrl_s;

endpackage

// ### verilog/line_sync.sv
// three-stage synchroniser for one port's d+/d- pair
`timescale 1ns/1ps
`default_nettype none

module line_sync (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [1:0] lineIn,
    output logic      [1:0] lineOut
);

    usb_line_pkg::line_sync_s r_r;
    usb_line_pkg::line_sync_s r_nxt;

    // ======================================================================
    // stage chain; stable value moves only when stages two and three agree
    always_comb begin
        r_nxt        = r_r;
        r_nxt.stage1 = lineIn;
        r_nxt.stage2 = r_r.stage1;
        r_nxt.stage3 = r_r.stage2;
        if (r_r.stage2 == r_r.stage3) begin
            r_nxt.stable = r_r.stage3;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign lineOut = r_r.stable;

endmodule

`default_nettype wire

// ### verilog/usb_port_line_control.sv
// line control and monitoring for two usb ports, one control register per serial engine
// Functional notes
// - two identical control registers, port 1 and port 2, at fixed addresses.
// - read-only bit reports live d+ level of the port.
// - read-only bit reports live d- level of the port.
// - speed bit set selects low speed, clear selects full speed.
// - role bit set selects host, clear selects peripheral device.
// - device role activates only the port chosen by the external port select.
// - resistor enable clear disconnects every pull-up and pull-down on the port.
// - enabled resistors in host role pull both lines down.
// - enabled device role pulls d- up at low speed, d+ at full speed.
// - force field gives normal, se0, j or k on the lines.
// - force field acts whatever the port select says.
// - suspend on either port powers both transceivers down, wakeup still watched.
// - host role with marker enable and force normal emits sof at full, keepalive at low speed, none in suspend.
// - both on-chip processor and host processor port read and write registers.
`timescale 1ns/1ps
`default_nettype none
`include "usb_port_line_control_params.svh"

module usb_port_line_control #(
    parameter int FRAME_CYCLES = `FRAME_PERIOD_NS / `CLOCK_PERIOD_NS
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [15:0] cpuAddr,
    input  wire logic        cpuWrite,
    input  wire logic        cpuRead,
    input  wire logic [15:0] cpuWdata,
    output logic      [15:0] cpuRdata,
    input  wire logic [15:0] hppAddr,
    input  wire logic        hppWrite,
    input  wire logic        hppRead,
    input  wire logic [15:0] hppWdata,
    output logic      [15:0] hppRdata,
    input  wire logic        portSelect,
    input  wire logic [1:0]  lineDpIn,
    input  wire logic [1:0]  lineDmIn,
    output logic      [1:0]  pullUpDp,
    output logic      [1:0]  pullUpDm,
    output logic      [1:0]  pullDownDp,
    output logic      [1:0]  pullDownDm,
    output logic      [1:0]  driveDp,
    output logic      [1:0]  driveDm,
    output logic      [1:0]  driveOe,
    output logic      [1:0]  portActive,
    output logic      [1:0]  sofPulse,
    output logic      [1:0]  keepalivePulse,
    output logic      [1:0]  wakeupSeen,
    output logic             transceiverPowerDown
);

    localparam logic [`FRAME_CNT_W-1:0] FRAME_LAST = `FRAME_CNT_W'(FRAME_CYCLES - 1);

    usb_line_pkg::line_ctrl_s r_r;
    usb_line_pkg::line_ctrl_s r_nxt;
    logic [1:0]               lineDpSync;
    logic [1:0]               lineDmSync;

    // ======================================================================
    // line synchronisers, one per port
    for (genvar p = 0; p < 2; p++) begin : gSync
        line_sync uSync (
            .clock   (clock),
            .rst_n   (rst_n),
            .lineIn  ({lineDpIn[p], lineDmIn[p]}),
            .lineOut ({lineDpSync[p], lineDmSync[p]})
        );
    end

    // ======================================================================
    // register read value
    function automatic logic [15:0] readWord(input logic [15:0] addr);
        logic [15:0] word;
        word = `READ_ZERO;
        for (int i = 0; i < 2; i++) begin
            if (addr == (i == 0 ? `PORT1_CTRL_ADDR : `PORT2_CTRL_ADDR)) begin
                word = r_r.ctrl[i] & `CTRL_WRITE_MASK;
                word[`BIT_DP_STATUS] = lineDpSync[i];
                word[`BIT_DM_STATUS] = lineDmSync[i];
            end
        end
        return word;
    endfunction

    // ======================================================================
    // next state
    always_comb begin
        logic [15:0] c;
        logic        anySuspend;
        logic        host;
        logic        lowSpeed;
        logic        resEn;
        logic        run;
        logic [1:0]  idle;
        c          = `CTRL_RESET;
        host       = 1'b0;
        lowSpeed   = 1'b0;
        resEn      = 1'b0;
        run        = 1'b0;
        idle       = `LINE_J_FULL;
        r_nxt      = r_r;
        anySuspend = r_r.ctrl[0][`BIT_SUSPEND] | r_r.ctrl[1][`BIT_SUSPEND];
        r_nxt.powerDown = anySuspend;
        for (int i = 0; i < 2; i++) begin
            // host processor port first so the on-chip processor wins a tie
            if (hppWrite && hppAddr == (i == 0 ? `PORT1_CTRL_ADDR : `PORT2_CTRL_ADDR)) begin
                r_nxt.ctrl[i] = hppWdata & `CTRL_WRITE_MASK;
            end
            if (cpuWrite && cpuAddr == (i == 0 ? `PORT1_CTRL_ADDR : `PORT2_CTRL_ADDR)) begin
                r_nxt.ctrl[i] = cpuWdata & `CTRL_WRITE_MASK;
            end
            c        = r_r.ctrl[i];
            host     = c[`BIT_HOST_ROLE];
            lowSpeed = c[`BIT_LOW_SPEED];
            resEn    = c[`BIT_RES_ENABLE];
            // resistor network
            r_nxt.pullDownDp[i] = resEn & host;
            r_nxt.pullDownDm[i] = resEn & host;
            r_nxt.pullUpDp[i]   = resEn & ~host & ~lowSpeed;
            r_nxt.pullUpDm[i]   = resEn & ~host & lowSpeed;
            // host role uses both ports, device role only the selected one
            r_nxt.portActive[i] = ~anySuspend & (host | (portSelect == 1'(i)));
            // line forcing, independent of port select
            unique case (c[`FORCE_MSB:`FORCE_LSB])
                `FORCE_NORMAL: begin
                    r_nxt.driveOe[i] = 1'b0;
                    r_nxt.driveDp[i] = 1'b0;
                    r_nxt.driveDm[i] = 1'b0;
                end
                `FORCE_SE0: begin
                    r_nxt.driveOe[i] = 1'b1;
                    r_nxt.driveDp[i] = 1'b0;
                    r_nxt.driveDm[i] = 1'b0;
                end
                `FORCE_J: begin
                    r_nxt.driveOe[i] = 1'b1;
                    r_nxt.driveDp[i] = ~lowSpeed;
                    r_nxt.driveDm[i] = lowSpeed;
                end
                `FORCE_K: begin
                    r_nxt.driveOe[i] = 1'b1;
                    r_nxt.driveDp[i] = lowSpeed;
                    r_nxt.driveDm[i] = ~lowSpeed;
                end
            endcase
            // wakeup watch: any departure from idle j while suspended
            idle = lowSpeed ? `LINE_J_LOW : `LINE_J_FULL;
            r_nxt.wakeupSeen[i] = anySuspend & ({lineDpSync[i], lineDmSync[i]} != idle);
            // frame markers
            run = host & c[`BIT_FRAME_EN] & r_r.portActive[i]
                & (c[`FORCE_MSB:`FORCE_LSB] == `FORCE_NORMAL);
            r_nxt.sofPulse[i]       = 1'b0;
            r_nxt.keepalivePulse[i] = 1'b0;
            if (!run) begin
                r_nxt.frameCnt[i] = '0;
            end else if (r_r.frameCnt[i] == FRAME_LAST) begin
                r_nxt.frameCnt[i]       = '0;
                r_nxt.sofPulse[i]       = ~lowSpeed;
                r_nxt.keepalivePulse[i] = lowSpeed;
            end else begin
                r_nxt.frameCnt[i] = r_r.frameCnt[i] + `FRAME_CNT_W'(1);
            end
        end
        // register reads
        if (cpuRead) begin
            r_nxt.cpuRdata = readWord(cpuAddr);
        end
        if (hppRead) begin
            r_nxt.hppRdata = readWord(hppAddr);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ======================================================================
    // outputs
    assign cpuRdata             = r_r.cpuRdata;
    assign hppRdata             = r_r.hppRdata;
    assign pullUpDp             = r_r.pullUpDp;
    assign pullUpDm             = r_r.pullUpDm;
    assign pullDownDp           = r_r.pullDownDp;
    assign pullDownDm           = r_r.pullDownDm;
    assign driveDp              = r_r.driveDp;
    assign driveDm              = r_r.driveDm;
    assign driveOe              = r_r.driveOe;
    assign portActive           = r_r.portActive;
    assign sofPulse             = r_r.sofPulse;
    assign keepalivePulse       = r_r.keepalivePulse;
    assign wakeupSeen           = r_r.wakeupSeen;
    assign transceiverPowerDown = r_r.powerDown;

    // ======================================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    for (genvar g = 0; g < 2; g++) begin : gChk
        localparam logic [15:0] ADDR = (g == 0) ? `PORT1_CTRL_ADDR : `PORT2_CTRL_ADDR;

        sequence cpuWriteHere;
            cpuWrite && cpuAddr == ADDR;
        endsequence

        sequence cpuReadBack;
            cpuRead && cpuAddr == ADDR && !cpuWrite ##1 1'b1;
        endsequence

        AST_RES_OFF: assert property (!r_r.ctrl[g][`BIT_RES_ENABLE] |=>
            !pullUpDp[g] && !pullUpDm[g] && !pullDownDp[g] && !pullDownDm[g])
            else $error("resistor left connected while disabled");
        AST_HOST_PULLDOWN: assert property (
            r_r.ctrl[g][`BIT_RES_ENABLE] && r_r.ctrl[g][`BIT_HOST_ROLE] |=>
            pullDownDp[g] && pullDownDm[g] && !pullUpDp[g] && !pullUpDm[g])
            else $error("host pull-downs wrong");
        AST_DEV_PULLUP: assert property (
            r_r.ctrl[g][`BIT_RES_ENABLE] && !r_r.ctrl[g][`BIT_HOST_ROLE] |=>
            pullUpDm[g] == $past(r_r.ctrl[g][`BIT_LOW_SPEED])
            && pullUpDp[g] == !$past(r_r.ctrl[g][`BIT_LOW_SPEED]) && !pullDownDp[g])
            else $error("device pull-up wrong");
        AST_FORCE_SE0: assert property (
            r_r.ctrl[g][`FORCE_MSB:`FORCE_LSB] == `FORCE_SE0 |=>
            driveOe[g] && !driveDp[g] && !driveDm[g])
            else $error("se0 not forced");
        AST_FORCE_K: assert property (
            r_r.ctrl[g][`FORCE_MSB:`FORCE_LSB] == `FORCE_K |=>
            driveOe[g] && driveDp[g] == $past(r_r.ctrl[g][`BIT_LOW_SPEED]))
            else $error("k state wrong");
        AST_CPU_WRITE: assert property (cpuWriteHere |=>
            r_r.ctrl[g][`BIT_LOW_SPEED] == $past(cpuWdata[`BIT_LOW_SPEED])
            && r_r.ctrl[g][`BIT_HOST_ROLE] == $past(cpuWdata[`BIT_HOST_ROLE]))
            else $error("processor write lost");
        AST_HPP_WRITE: assert property (
            hppWrite && hppAddr == ADDR && !(cpuWrite && cpuAddr == ADDR) |=>
            r_r.ctrl[g][`BIT_HOST_ROLE] == $past(hppWdata[`BIT_HOST_ROLE]))
            else $error("host port write lost");
        AST_STATUS_READ: assert property (cpuReadBack |->
            cpuRdata[`BIT_DP_STATUS] == $past(lineDpSync[g])
            && cpuRdata[`BIT_DM_STATUS] == $past(lineDmSync[g])
            && cpuRdata[15:14] == 2'h0)
            else $error("line status read wrong");
        AST_MARKER_PERIOD: assert property (
            sofPulse[g] || keepalivePulse[g] |->
            $past(r_r.frameCnt[g]) == FRAME_LAST && $past(r_r.ctrl[g][`BIT_HOST_ROLE])
            && sofPulse[g] == !$past(r_r.ctrl[g][`BIT_LOW_SPEED]))
            else $error("frame marker timing wrong");
    end

    AST_POWER_DOWN: assert property (
        r_r.ctrl[0][`BIT_SUSPEND] || r_r.ctrl[1][`BIT_SUSPEND] |=>
        transceiverPowerDown && portActive == 2'h0)
        else $error("suspend did not power down");

endmodule

`default_nettype wire

// ### testbench/usb_peer_model.sv
// usb peer on the data lines of both ports, with the line level resolved against forced drive
`timescale 1ns/1ps
`default_nettype none

module usb_peer_model (
    input  wire logic [1:0] peerDp,
    input  wire logic [1:0] peerDm,
    input  wire logic [1:0] driveDp,
    input  wire logic [1:0] driveDm,
    input  wire logic [1:0] driveOe,
    output logic      [1:0] lineDp,
    output logic      [1:0] lineDm
);
    // ======================================================================
    // wire level: a forcing port overrides the peer
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            lineDp[i] = driveOe[i] ? driveDp[i] : peerDp[i];
            lineDm[i] = driveOe[i] ? driveDm[i] : peerDm[i];
        end
    end
endmodule
`default_nettype wire

// ### testbench/usb_port_line_control_tb.sv
// self-checking bench of the port line control
`timescale 1ns/1ps
`default_nettype none
`include "usb_port_line_control_params.svh"

module usb_port_line_control_tb;
    localparam int FC = 20;
    logic        clock, rst_n, cpuWrite, cpuRead, hppWrite, hppRead, portSelect;
    logic [15:0] cpuAddr, cpuWdata, cpuRdata, hppAddr, hppWdata, hppRdata;
    logic [1:0]  lineDp, lineDm, peerDp, peerDm, pullUpDp, pullUpDm, pullDownDp, pullDownDm;
    logic [1:0]  driveDp, driveDm, driveOe, portActive, sofPulse, keepalivePulse, wakeupSeen;
    logic        transceiverPowerDown;
    logic [15:0] shadow [2];
    int          n_errors, check_count, seed, n;

    usb_port_line_control #(.FRAME_CYCLES(FC)) u_usb_port_line_control (
        .clock(clock), .rst_n(rst_n), .cpuAddr(cpuAddr), .cpuWrite(cpuWrite),
        .cpuRead(cpuRead), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata), .hppAddr(hppAddr),
        .hppWrite(hppWrite), .hppRead(hppRead), .hppWdata(hppWdata), .hppRdata(hppRdata),
        .portSelect(portSelect), .lineDpIn(lineDp), .lineDmIn(lineDm),
        .pullUpDp(pullUpDp), .pullUpDm(pullUpDm), .pullDownDp(pullDownDp),
        .pullDownDm(pullDownDm), .driveDp(driveDp), .driveDm(driveDm), .driveOe(driveOe),
        .portActive(portActive), .sofPulse(sofPulse), .keepalivePulse(keepalivePulse),
        .wakeupSeen(wakeupSeen), .transceiverPowerDown(transceiverPowerDown));

    usb_peer_model u_usb_peer_model (
        .peerDp(peerDp), .peerDm(peerDm), .driveDp(driveDp), .driveDm(driveDm),
        .driveOe(driveOe), .lineDp(lineDp), .lineDm(lineDm));

    // ======================================================================
    // clock, checks and verdict
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ======================================================================
    // expectations
    function automatic logic [3:0] expRes(input logic [15:0] c);
        if (!c[`BIT_RES_ENABLE]) return 4'h0;
        if (c[`BIT_HOST_ROLE]) return 4'h3;
        return c[`BIT_LOW_SPEED] ? 4'h4 : 4'h8;
    endfunction

    function automatic logic [2:0] expForce(input logic [15:0] c);
        case (c[`FORCE_MSB:`FORCE_LSB])
            `FORCE_SE0: return 3'h4;
            `FORCE_J:   return c[`BIT_LOW_SPEED] ? 3'h5 : 3'h6;
            `FORCE_K:   return c[`BIT_LOW_SPEED] ? 3'h6 : 3'h5;
            default:    return 3'h0;
        endcase
    endfunction

    function automatic logic [15:0] expRead(input int p);
        logic [2:0] f;
        f = expForce(shadow[p]);
        if (f[2]) return {2'h0, f[1:0], 12'h000} | shadow[p];
        return {2'h0, peerDp[p], peerDm[p], 12'h000} | shadow[p];
    endfunction

    function automatic logic [15:0] addrOf(input int p);
        return p ? `PORT2_CTRL_ADDR : `PORT1_CTRL_ADDR;
    endfunction

    // ======================================================================
    // register port cycles, either processor port
    task automatic bus(input logic hp, input logic wr, input logic [15:0] a,
                       input logic [15:0] d);
        @(posedge clock);
        #1;
        if (hp) begin
            hppAddr = a; hppWdata = d; hppWrite = wr; hppRead = !wr;
        end else begin
            cpuAddr = a; cpuWdata = d; cpuWrite = wr; cpuRead = !wr;
        end
        @(posedge clock);
        #1;
        cpuWrite = 1'b0; cpuRead = 1'b0; hppWrite = 1'b0; hppRead = 1'b0;
    endtask

    task automatic rd(input logic hp, input logic [15:0] a, input logic [15:0] e);
        bus(hp, 1'b0, a, 16'h0000);
        chk(hp ? hppRdata : cpuRdata, e);
    endtask

    task automatic apply(input int p, input logic hp, input logic [15:0] d);
        logic act;
        portSelect = 1'($random(seed));
        peerDp = 2'($random(seed));
        peerDm = 2'($random(seed));
        shadow[p] = d & `CTRL_WRITE_MASK;
        bus(hp, 1'b1, addrOf(p), shadow[p]);
        repeat (2) @(posedge clock);
        #1;
        act = !(shadow[0][`BIT_SUSPEND] | shadow[1][`BIT_SUSPEND]);
        act = act & (shadow[p][`BIT_HOST_ROLE] | (portSelect == p[0]));
        chk({pullUpDp[p], pullUpDm[p], pullDownDp[p], pullDownDm[p]}, expRes(shadow[p]));
        chk({driveOe[p], driveDp[p], driveDm[p]}, expForce(shadow[p]));
        chk(portActive[p], act);
        repeat (6) @(posedge clock);
        #1;
        rd(!hp, addrOf(p), expRead(p));
    endtask

    task automatic period(input logic low);
        n = 0;
        while (!(low ? keepalivePulse[0] : sofPulse[0]) && n < 3 * FC) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk(n < 3 * FC, 1'b1);
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
            chk(low ? sofPulse[0] : keepalivePulse[0], 1'b0);
        end while (!(low ? keepalivePulse[0] : sofPulse[0]) && n < 3 * FC);
        chk(16'(n), 16'(FC));
    endtask

    // ======================================================================
    // main sequence
    initial begin
        logic [15:0] d;
        n_errors = 0; check_count = 0; seed = 32'h3caa94a5;
        rst_n = 1'b0; portSelect = 1'b0; peerDp = 2'h3; peerDm = 2'h0;
        cpuAddr = 16'h0000; cpuWrite = 1'b0; cpuRead = 1'b0; cpuWdata = 16'h0000;
        hppAddr = 16'h0000; hppWrite = 1'b0; hppRead = 1'b0; hppWdata = 16'h0000;
        shadow[0] = `CTRL_RESET; shadow[1] = `CTRL_RESET;
        repeat (6) @(posedge clock);
        #1;
        rst_n = 1'b1;
        chk({pullUpDp, pullUpDm, pullDownDp, pullDownDm, driveOe, portActive}, 16'h0000);
        repeat (6) @(posedge clock);
        #1;
        rd(1'b0, `PORT1_CTRL_ADDR, expRead(0));
        rd(1'b1, `PORT2_CTRL_ADDR, expRead(1));
        for (int i = 0; i < 64; i++) begin
            d = {5'h00, i[4], i[3], 1'h0, i[2], 2'h0, i[1:0], 3'h0};
            apply(i[5], i[0], d);
        end
        for (int i = 0; i < 24; i++) begin
            d = 16'($random(seed)) & 16'hFFFB;
            if (!d[`BIT_HOST_ROLE]) d[`BIT_FRAME_EN] = 1'b0;
            apply($random(seed) & 1, 1'($random(seed)), d);
        end
        bus(1'b0, 1'b1, 16'hC08C, 16'h0680);
        rd(1'b0, 16'hC08C, `READ_ZERO);
        rd(1'b1, `PORT1_CTRL_ADDR, expRead(0));
        apply(0, 1'b0, 16'h0201);
        period(1'b0);
        apply(0, 1'b1, 16'h0601);
        period(1'b1);
        apply(0, 1'b0, 16'h0000);
        apply(1, 1'b1, 16'h0004);
        chk(transceiverPowerDown, 1'b1);
        peerDp[0] = 1'b1;
        peerDm[0] = 1'b0;
        repeat (8) @(posedge clock);
        #1;
        chk(wakeupSeen[0], 1'b0);
        peerDp[0] = 1'b0;
        peerDm[0] = 1'b1;
        repeat (8) @(posedge clock);
        #1;
        chk(wakeupSeen[0], 1'b1);
        apply(1, 1'b0, 16'h0000);
        chk(transceiverPowerDown, 1'b0);
        print_verdict();
    end

    initial begin
        #(100 * 50000);
        n_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
